// *** rtl/sar_adc_control.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// R1 - Pin enable bit routes pin to analog
// R2 - Upper two pin bits read zero; reset zero
// R3 - Reference select: supply or external pin
// R4 - Rate field picks divide by 4,1,16,2
// R5 - One divided clock per bit, sixteen periods
// R6 - Writing run one starts conversion, stays set
// R7 - Writing run zero does nothing
// R8 - Power bit zero switches ladder off
// R9 - Channel codes zero to five select inputs
// R10 - Channel changes only while idle, flag low
// R11 - Completion loads result, clears run, sets flag
// R12 - Ten-bit successive approximation result
// R13 - Software waits acquisition time before starting
// R14 - Flag set regardless of enables
// R15 - Enabled flagged interrupt fetches vector 0030
// R16 - Service routine clears flag before return
// R17 - Return operation sets global enable again
// R18 - Software avoids port output during conversion
// R19 - Sleep completion wakes, else converter shuts off
// R20 - Run write during conversion is ignored
// R21 - Undefined channel connects no input
module sar_adc_control
  import sar_adc_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic COMP_IN,
  input wire logic SLEEP,
  output logic [RES_W-1:0] DAC_CODE,
  output logic [PIN_COUNT-1:0] PIN_ANALOG,
  output logic [PIN_COUNT-1:0] SAMPLE_SEL,
  output logic REF_EXTERNAL,
  output logic LADDER_ON,
  output logic SAMPLE_HOLD,
  output logic IRQ_REQ,
  output logic [11:0] IRQ_VECTOR,
  output logic [2:0] IRQ_PRIORITY,
  output logic WAKE
);

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  // Divider terminal count for a rate code
  function automatic logic [3:0] div_limit(input logic [1:0] rate);
    unique case (rate)
      RATE_DIV4: div_limit = 4'h3;
      RATE_DIV1: div_limit = 4'h0;
      RATE_DIV16: div_limit = 4'hF;
      RATE_DIV2: div_limit = 4'h1;
    endcase
  endfunction

  // One-hot input select, empty for undefined codes
  function automatic logic [PIN_COUNT-1:0] chan_onehot(
    input logic [2:0] ch);
    chan_onehot = '0;
    if (ch <= CH_LAST) begin
      chan_onehot[ch] = 1'b1;
    end
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  addr_phase_s aph_q;
  logic rd_wait_q;
  logic [31:0] hrdata_q;
  logic [PIN_COUNT-1:0] pin_sel_q;
  control_s ctl_q;
  conv_state_e state_q;
  logic [3:0] div_q;
  logic [3:0] bitcnt_q;
  logic [RES_W-1:0] sar_q;
  logic [RES_W-1:0] result_q;
  logic flag_q;
  logic ie_q;
  logic we_q;
  logic gie_q;
  logic shut_q;
  logic wake_q;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire logic accept = HSEL & HTRANS[1] & HREADY;
  wire logic wr_act = aph_q.valid & aph_q.write;
  wire logic [7:0] wbyte = HWDATA[7:0];
  wire logic wr_pin = wr_act & (aph_q.addr == OFF_PIN_SEL);
  wire logic wr_ctl = wr_act & (aph_q.addr == OFF_CONTROL);
  wire logic wr_irq = wr_act & (aph_q.addr == OFF_IRQ_CTL);
  wire logic wr_op = wr_act & (aph_q.addr == OFF_CPU_OP);
  wire logic running = (state_q == ST_CONV);

  // Read mux; unmapped addresses read zero
  logic [7:0] rd_byte;
  always_comb begin
    unique case (aph_q.addr)
      OFF_PIN_SEL: rd_byte = {2'h0, pin_sel_q}; // R2
      OFF_CONTROL: rd_byte = {ctl_q.ref_ext, ctl_q.rate, running,
                              ctl_q.power_on, ctl_q.channel};
      OFF_RES_HI: rd_byte = {6'h00, result_q[9:8]};
      OFF_RES_LO: rd_byte = result_q[7:0];
      OFF_IRQ_CTL: rd_byte = {4'h0, gie_q, we_q, ie_q, flag_q};
      default: rd_byte = 8'h00;
    endcase
  end

  // Address phase capture
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      aph_q <= '0;
    end else if (accept) begin
      aph_q <= '{valid: 1'b1, write: HWRITE, addr: HADDR[7:0]};
    end else if (HREADYOUT) begin
      aph_q <= '0;
    end
  end

  // One wait state on reads so prior writes are visible
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rd_wait_q <= 1'b0;
      hrdata_q <= 32'h0000_0000;
    end else begin
      rd_wait_q <= accept & ~HWRITE;
      if (rd_wait_q) begin
        hrdata_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  assign HRDATA = hrdata_q;
  assign HREADYOUT = ~rd_wait_q;
  assign HRESP = 1'b0;

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  wire logic ch_locked = running | flag_q;
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      pin_sel_q <= PIN_SEL_RST[PIN_COUNT-1:0]; // R2
      ctl_q <= '{ref_ext: CONTROL_RST[CTL_REF],
                 rate: CONTROL_RST[CTL_RATE_HI:CTL_RATE_LO],
                 power_on: CONTROL_RST[CTL_PWR],
                 channel: CONTROL_RST[CTL_CH_HI:0]};
    end else begin
      if (wr_pin) begin
        pin_sel_q <= wbyte[PIN_COUNT-1:0]; // R1
      end
      if (wr_ctl) begin
        ctl_q.ref_ext <= wbyte[CTL_REF]; // R3
        ctl_q.rate <= wbyte[CTL_RATE_HI:CTL_RATE_LO]; // R4
        ctl_q.power_on <= wbyte[CTL_PWR]; // R8
        if (!ch_locked) begin
          ctl_q.channel <= wbyte[CTL_CH_HI:0]; // R10
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Conversion sequencer
  // ---------------------------------------------------------------
  wire logic start = wr_ctl & wbyte[CTL_RUN] & ~running; // R6 R7 R20
  wire logic tick = running & (div_q == div_limit(ctl_q.rate)); // R4
  wire logic resolving = running & (bitcnt_q >= FIRST_RESOLVE);
  wire logic [3:0] bit_idx = 4'(BIT_PERIODS_LAST - bitcnt_q);
  wire logic [RES_W-1:0] trial =
    resolving ? RES_W'(1 << bit_idx) : '0;
  wire logic done_evt = tick & (bitcnt_q == BIT_PERIODS_LAST); // R5

  // Divider and bit period counter
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state_q <= ST_IDLE;
      div_q <= 4'h0;
      bitcnt_q <= 4'h0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          div_q <= 4'h0;
          bitcnt_q <= 4'h0;
          if (start) begin
            state_q <= ST_CONV; // R6
          end
        end
        ST_CONV: begin
          div_q <= tick ? 4'h0 : 4'(div_q + 4'h1);
          if (tick) begin
            bitcnt_q <= 4'(bitcnt_q + 4'h1); // R5
          end
          if (done_evt) begin
            state_q <= ST_IDLE; // R11
          end
        end
      endcase
    end
  end

  // Successive approximation, one bit per period
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      sar_q <= '0;
      result_q <= '0;
    end else begin
      if (start) begin
        sar_q <= '0;
      end else if (tick && resolving && COMP_IN) begin
        sar_q <= sar_q | trial; // R12
      end
      if (done_evt) begin
        result_q <= sar_q | (COMP_IN ? trial : '0); // R11
      end
    end
  end

  // ---------------------------------------------------------------
  // Flag, interrupt enables and wake
  // ---------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      flag_q <= 1'b0;
      ie_q <= 1'b0;
      we_q <= 1'b0;
      gie_q <= 1'b0;
      shut_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      // Completion beats a clear in the same cycle
      if (done_evt) begin
        flag_q <= 1'b1; // R14
      end else if (wr_irq && !wbyte[IRQ_FLAG]) begin
        flag_q <= 1'b0;
      end
      if (wr_irq) begin
        ie_q <= wbyte[IRQ_IE];
        we_q <= wbyte[IRQ_WE];
      end
      if (wr_op && (wbyte[OP_ENABLE] || wbyte[OP_RETURN])) begin
        gie_q <= 1'b1; // R17
      end else if (wr_op && wbyte[OP_DISABLE]) begin
        gie_q <= 1'b0;
      end else if (wr_irq) begin
        gie_q <= wbyte[IRQ_GIE];
      end
      if (!SLEEP) begin
        shut_q <= 1'b0;
      end else if (done_evt && !we_q) begin
        shut_q <= 1'b1; // R19
      end
      wake_q <= done_evt & SLEEP & we_q; // R19
    end
  end

  // ---------------------------------------------------------------
  // Analog side controls
  // ---------------------------------------------------------------
  assign PIN_ANALOG = pin_sel_q; // R1
  assign SAMPLE_SEL = chan_onehot(ctl_q.channel); // R9 R21
  assign REF_EXTERNAL = ctl_q.ref_ext; // R3
  assign LADDER_ON = ctl_q.power_on & ~shut_q; // R8 R19
  assign SAMPLE_HOLD = running & ~resolving;
  assign DAC_CODE = sar_q | trial; // R12
  assign IRQ_REQ = gie_q & ie_q & flag_q; // R15
  assign IRQ_VECTOR = IRQ_VECTOR_ADDR; // R15
  assign IRQ_PRIORITY = IRQ_PRIO_LEVEL; // R15
  assign WAKE = wake_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_start_fast;
    $rose(running) && ctl_q.rate == RATE_DIV1;
  endsequence

  sequence s_complete;
    !running && flag_q;
  endsequence

  a_conv_length_div1: assert property ( // R5
    @(posedge CLOCK) disable iff (RST)
    s_start_fast |-> ##16 s_complete)
    else $error("conversion at divide by one not 16 cycles");

  a_run_held: assert property ( // R6
    @(posedge CLOCK) disable iff (RST)
    start |=> running [*3])
    else $error("run bit dropped early");

  a_no_sw_clear: assert property ( // R7
    @(posedge CLOCK) disable iff (RST)
    running && !done_evt |=> running)
    else $error("run bit cleared without completion");

  a_done_effects: assert property ( // R11
    @(posedge CLOCK) disable iff (RST)
    done_evt |=> !running && flag_q
      && result_q[RES_W-1:1] == $past(DAC_CODE[RES_W-1:1])
      && result_q[0] == $past(COMP_IN))
    else $error("completion did not load result, clear run, set flag");

  a_chan_locked: assert property ( // R10
    @(posedge CLOCK) disable iff (RST)
    ch_locked |=> $stable(ctl_q.channel))
    else $error("channel changed while busy or flagged");

  a_upper_zero: assert property ( // R2
    @(posedge CLOCK) disable iff (RST)
    rd_wait_q && aph_q.addr == OFF_PIN_SEL |=> HRDATA[7:6] == 2'h0)
    else $error("unused pin select bits read nonzero");

  a_irq_vector: assert property ( // R15
    @(posedge CLOCK) disable iff (RST)
    gie_q && ie_q && flag_q |-> IRQ_REQ && IRQ_VECTOR == 12'h030)
    else $error("enabled interrupt not requested");

  a_return_gie: assert property ( // R17
    @(posedge CLOCK) disable iff (RST)
    wr_op && wbyte[OP_RETURN] |=> gie_q)
    else $error("return did not set global enable");

  a_undef_chan: assert property ( // R21
    @(posedge CLOCK) disable iff (RST)
    ctl_q.channel > CH_LAST |-> SAMPLE_SEL == '0)
    else $error("undefined channel connected an input");

  a_sleep_shut: assert property ( // R19
    @(posedge CLOCK) disable iff (RST)
    done_evt && SLEEP && !we_q |=> !LADDER_ON || !SLEEP)
    else $error("converter not shut off after sleep completion");

  a_wake_pulse: assert property ( // R19
    @(posedge CLOCK) disable iff (RST)
    done_evt && SLEEP && we_q |=> WAKE ##1 !WAKE)
    else $error("wake not pulsed");

endmodule // sar_adc_control

// *** inc/sar_adc_pkg.sv ***
package sar_adc_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses, one word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_PIN_SEL = 8'h00;
  localparam logic [7:0] OFF_CONTROL = 8'h04;
  localparam logic [7:0] OFF_RES_HI = 8'h08;
  localparam logic [7:0] OFF_RES_LO = 8'h0C;
  localparam logic [7:0] OFF_IRQ_CTL = 8'h10;
  localparam logic [7:0] OFF_CPU_OP = 8'h14;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int PIN_COUNT = 6;
  localparam int RES_W = 10;
  localparam int CTL_REF = 7;
  localparam int CTL_RATE_HI = 6;
  localparam int CTL_RATE_LO = 5;
  localparam int CTL_RUN = 4;
  localparam int CTL_PWR = 3;
  localparam int CTL_CH_HI = 2;
  localparam int IRQ_FLAG = 0;
  localparam int IRQ_IE = 1;
  localparam int IRQ_WE = 2;
  localparam int IRQ_GIE = 3;
  localparam int OP_ENABLE = 0;
  localparam int OP_DISABLE = 1;
  localparam int OP_RETURN = 2;
  localparam logic [7:0] PIN_SEL_RST = 8'h00;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [2:0] CH_LAST = 3'h5;

  // ---------------------------------------------------------------
  // Conversion timing and interrupt entry
  // ---------------------------------------------------------------
  localparam logic [3:0] BIT_PERIODS_LAST = 4'hF;
  localparam logic [3:0] FIRST_RESOLVE = 4'h6;
  localparam logic [1:0] RATE_DIV4 = 2'h0;
  localparam logic [1:0] RATE_DIV1 = 2'h1;
  localparam logic [1:0] RATE_DIV16 = 2'h2;
  localparam logic [1:0] RATE_DIV2 = 2'h3;
  localparam logic [11:0] IRQ_VECTOR_ADDR = 12'h030;
  localparam logic [2:0] IRQ_PRIO_LEVEL = 3'h6;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } conv_state_e;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } addr_phase_s;

  typedef struct packed {
    logic ref_ext;
    logic [1:0] rate;
    logic power_on;
    logic [2:0] channel;
  } control_s;

endpackage

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import sar_adc_pkg::*;

  // ---------------------------------------------------------------
  // Bench signals
  // ---------------------------------------------------------------
  logic CLOCK, RST, HSEL, HWRITE, COMP_IN, SLEEP;
  logic [31:0] HADDR, HWDATA, HRDATA, rd;
  logic [1:0] HTRANS;
  logic HREADYOUT, HRESP, LADDER_ON, REF_EXTERNAL, SAMPLE_HOLD;
  logic IRQ_REQ, WAKE;
  logic [RES_W-1:0] DAC_CODE, vin;
  logic [PIN_COUNT-1:0] PIN_ANALOG, SAMPLE_SEL;
  logic [11:0] IRQ_VECTOR;
  logic [2:0] IRQ_PRIORITY;
  int fails, checks, cyc, t0, wakes;
  logic [7:0] offs [7] = '{OFF_PIN_SEL, OFF_CONTROL, OFF_RES_HI,
    OFF_RES_LO, OFF_IRQ_CTL, OFF_CPU_OP, 8'h18};
  logic [7:0] ops [6] = '{8'h02, 8'h01, 8'h02, 8'h04, 8'h02, 8'h03};
  logic [7:0] opx [6] = '{8'h02, 8'h0A, 8'h02, 8'h0A, 8'h02, 8'h0A};
  logic [9:0] vt [4] = '{10'h2A5, 10'h3FF, 10'h155, 10'h000};
  localparam int ACQ_CYCLES = 100; // Two microseconds of acquisition

  sar_adc_control u_dut (
    .CLOCK(CLOCK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .COMP_IN(COMP_IN), .SLEEP(SLEEP),
    .DAC_CODE(DAC_CODE), .PIN_ANALOG(PIN_ANALOG),
    .SAMPLE_SEL(SAMPLE_SEL), .REF_EXTERNAL(REF_EXTERNAL),
    .LADDER_ON(LADDER_ON), .SAMPLE_HOLD(SAMPLE_HOLD),
    .IRQ_REQ(IRQ_REQ), .IRQ_VECTOR(IRQ_VECTOR),
    .IRQ_PRIORITY(IRQ_PRIORITY), .WAKE(WAKE)
  );

  // ---------------------------------------------------------------
  // Clock, cycle count, comparator and wake pulse count
  // ---------------------------------------------------------------
  initial begin
    CLOCK = 1'b0;
    forever #10 CLOCK = ~CLOCK;
  end

  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    COMP_IN <= (vin >= DAC_CODE);
    if (WAKE === 1'b1) begin
      wakes <= wakes + 1;
    end
  end

  // ---------------------------------------------------------------
  // Compare, bus and verdict tasks
  // ---------------------------------------------------------------
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask

  // One single transfer: address phase, then data phase
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    HSEL <= 1'b1;
    HADDR <= {24'h0, a};
    HWRITE <= w;
    HTRANS <= 2'h2;
    do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= {24'h0, d};
    do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
    rd = HRDATA;
  endtask

  task rchk(input string n, input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(n, rd, {24'h0, e});
  endtask

  function automatic int divof(input logic [1:0] r);
    case (r)
      RATE_DIV1: return 1;
      RATE_DIV2: return 2;
      RATE_DIV16: return 16;
      default: return 4;
    endcase
  endfunction

  task complete_run;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One conversion at rate r against input v, optional meddling writes
  task conv(input logic [1:0] r, input logic [9:0] v, input bit meddle);
    int n;
    vin <= v;
    bus(1'b1, OFF_CONTROL, {1'b0, r, 2'b01, 3'h0});
    repeat (ACQ_CYCLES) @(posedge CLOCK);
    bus(1'b1, OFF_CONTROL, {1'b0, r, 2'b11, 3'h0});
    t0 = cyc;
    if (meddle) begin
      bus(1'b1, OFF_CONTROL, {1'b0, r, 2'b01, 3'h3});
      rchk("run held", OFF_CONTROL, {1'b0, r, 2'b11, 3'h0});
      bus(1'b1, OFF_CONTROL, {1'b0, r, 2'b11, 3'h0});
    end
    n = 0;
    while (IRQ_REQ !== 1'b1 && n < 400) begin
      @(posedge CLOCK);
      n++;
    end
    chk("conv time", cyc - t0, 16 * divof(r) + 1);
    chk("vector", IRQ_VECTOR, 12'h030);
    chk("prio", IRQ_PRIORITY, 3'h6);
    rchk("res hi", OFF_RES_HI, {6'h0, v[9:8]});
    rchk("res lo", OFF_RES_LO, v[7:0]);
    rchk("run clr", OFF_CONTROL, {1'b0, r, 2'b01, 3'h0});
    bus(1'b1, OFF_CONTROL, {1'b0, r, 2'b01, 3'h4});
    rchk("chan held", OFF_CONTROL, {1'b0, r, 2'b01, 3'h0});
    bus(1'b1, OFF_IRQ_CTL, 8'h0A);
    @(posedge CLOCK);
    chk("irq clr", IRQ_REQ, 32'h0);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    RST = 1'b1;
    HSEL = 1'b0;
    HADDR = 32'h0;
    HTRANS = 2'h0;
    HWRITE = 1'b0;
    HWDATA = 32'h0;
    COMP_IN = 1'b0;
    SLEEP = 1'b0;
    vin = 10'h000;
    fails = 0;
    checks = 0;
    cyc = 0;
    wakes = 0;
    repeat (2) @(posedge CLOCK);
    RST <= 1'b0;
    foreach (offs[i]) rchk("reset", offs[i], 8'h00);
    chk("ladder rst", LADDER_ON, 32'h0);
    chk("sel rst", SAMPLE_SEL, 32'h01);
    chk("resp", HRESP, 32'h0);
    bus(1'b1, OFF_PIN_SEL, 8'hFF);
    rchk("pin sel", OFF_PIN_SEL, 8'h3F);
    chk("pins", PIN_ANALOG, 32'h3F);
    bus(1'b1, OFF_PIN_SEL, 8'h15);
    rchk("pin sel", OFF_PIN_SEL, 8'h15);
    chk("pins", PIN_ANALOG, 32'h15);
    bus(1'b1, 8'h18, 8'hFF);
    rchk("unmapped", 8'h18, 8'h00);
    // Every channel code with external reference and power on
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, OFF_CONTROL, {5'b10001, c[2:0]});
      rchk("ctl", OFF_CONTROL, {5'b10001, c[2:0]});
      chk("sel", SAMPLE_SEL, c < 6 ? 32'h1 << c : 32'h0);
      chk("ref", REF_EXTERNAL, 32'h1);
      chk("ladder", LADDER_ON, 32'h1);
    end
    bus(1'b1, OFF_CONTROL, 8'h00);
    rchk("ctl", OFF_CONTROL, 8'h00);
    chk("ref", REF_EXTERNAL, 32'h0);
    chk("ladder", LADDER_ON, 32'h0);
    // Global enable operations
    bus(1'b1, OFF_IRQ_CTL, 8'h0A);
    foreach (ops[i]) begin
      bus(1'b1, OFF_CPU_OP, ops[i]);
      rchk("gie", OFF_IRQ_CTL, opx[i]);
    end
    // Conversions at every rate
    for (int r = 0; r < 4; r++) begin
      conv(r[1:0], vt[r], r == 2);
    end
    // Flag with interrupt masked
    bus(1'b1, OFF_IRQ_CTL, 8'h08);
    bus(1'b1, OFF_CONTROL, 8'h38);
    @(posedge CLOCK);
    chk("hold", SAMPLE_HOLD, 32'h1);
    repeat (19) @(posedge CLOCK);
    chk("masked", IRQ_REQ, 32'h0);
    chk("hold end", SAMPLE_HOLD, 32'h0);
    rchk("flag", OFF_IRQ_CTL, 8'h09);
    // Completion during sleep, with and without wake enable
    SLEEP <= 1'b1;
    bus(1'b1, OFF_IRQ_CTL, 8'h04);
    bus(1'b1, OFF_CONTROL, 8'h38);
    repeat (20) @(posedge CLOCK);
    chk("wake", wakes, 32'h1);
    chk("ladder on", LADDER_ON, 32'h1);
    bus(1'b1, OFF_IRQ_CTL, 8'h00);
    bus(1'b1, OFF_CONTROL, 8'h38);
    repeat (20) @(posedge CLOCK);
    chk("shut", LADDER_ON, 32'h0);
    chk("no wake", wakes, 32'h1);
    complete_run;
  end

  // ---------------------------------------------------------------
  // Watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge CLOCK);
    fails++;
    complete_run;
  end

endmodule // tb_top
